/* File: hdl/xint_pkg.sv */
// Constants and carrier types for the extra interrupt and extra port block.
// Assumes an 8051-style core that reaches these registers through its SFR port.
// Behaviour
// - Control register at SFR 0C0H, bit-addressable.
// - Bits: prio3,en3,pend3,trig3,prio2,en2,pend2,trig2.
// - Request passes only while its enable is set.
// - Priority bit one selects high service level.
// - Trigger one: falling edge; zero: low level.
// - Edge sets pending; vectoring clears it.
// - Fixed vector addresses 03H through 3BH.
// - Same level: grant in vector order.
// - Extra port latch at SFR 0D8H.
// - Only lower four port bits have pins.
// - Port pins behave like standard port one.
// - Port bits 3 and 2 double as interrupts.
// - Byte write drives pins, read returns pins.
// - Pins are quasi-bidirectional with pull-ups.
// - Reset: port latch FFH, control 00H.
package xint_pkg;
  localparam logic [7:0] CTRL_ADDR = 8'hC0;
  localparam logic [7:0] PORT_ADDR = 8'hD8;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] PORT_RESET = 8'hFF;
  localparam int TRIG2_BIT = 0;
  localparam int PEND2_BIT = 1;
  localparam int EN2_BIT = 2;
  localparam int PRIO2_BIT = 3;
  localparam int TRIG3_BIT = 4;
  localparam int PEND3_BIT = 5;
  localparam int EN3_BIT = 6;
  localparam int PRIO3_BIT = 7;
  localparam int PORT_PINS = 4;
  localparam int IRQ2_PIN = 2;
  localparam int IRQ3_PIN = 3;
  localparam int SOURCES = 8;
  localparam int SRC_IRQ2 = 6;
  localparam int SRC_IRQ3 = 7;
  localparam logic [7:0] VEC_BASE = 8'h03;
  localparam int VEC_STEP_SHIFT = 3;

  typedef struct packed {
    logic wr;
    logic rd;
    logic bit_op;
    logic [7:0] addr;
    logic [7:0] wdata;
  } sfr_req_t;

  typedef struct packed {
    logic valid;
    logic high;
    logic [2:0] source;
    logic [7:0] vector;
  } grant_t;
endpackage

/* File: hdl/xint_port.sv */
// Extra external interrupts, eight-source priority encoder and 4-bit extra port.
// Assumes the core presents one SFR access per cycle and acknowledges vectoring.
`timescale 1ns/1ps
module xint_port #(
  parameter int SYNC_STAGES = 3
)
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_n_i,
  // SFR access; for bit_op, addr is a bit address and wdata[0] the bit value
  input wire xint_pkg::sfr_req_t req_i,
  output logic [7:0] rdata_o,
  // Standard core sources, index 0..5, with their priority bits
  input wire logic [5:0] core_req_i,
  input wire logic [5:0] core_prio_i,
  // Core acknowledge of the source being vectored
  input wire logic ack_i,
  input wire logic [2:0] ack_source_i,
  // Interrupt grant
  output xint_pkg::grant_t grant_o,
  // Port pins
  input wire logic [3:0] pin_i,
  output logic [3:0] pin_o,
  output logic [3:0] pin_oe_n_o
);
  initial
  begin
    if (SYNC_STAGES != 3)
      $error("SYNC_STAGES must be 3");
  end

  logic [7:0] ctrl_r;
  logic [7:0] ctrl_nxt;
  logic [7:0] port_r;
  logic [7:0] port_nxt;
  logic [3:0] s1_r;
  logic [3:0] s2_r;
  logic [3:0] s3_r;
  logic [3:0] pin_r;
  logic [3:0] pin_nxt;
  logic [1:0] prev_r;
  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;
  xint_pkg::grant_t grant_r;
  xint_pkg::grant_t grant_nxt;

  // A change counts once stages two and three agree; stage one feeds stage two only.
  assign pin_nxt = (s2_r & s3_r) | (pin_r & (s2_r ^ s3_r));

  wire irq2_lvl = pin_r[xint_pkg::IRQ2_PIN];
  wire irq3_lvl = pin_r[xint_pkg::IRQ3_PIN];
  wire fall2 = prev_r[0] & ~irq2_lvl;
  wire fall3 = prev_r[1] & ~irq3_lvl;

  // SFR decode.
  wire ctrl_byte = ~req_i.bit_op && (req_i.addr == xint_pkg::CTRL_ADDR);
  wire port_byte = ~req_i.bit_op && (req_i.addr == xint_pkg::PORT_ADDR);
  wire ctrl_bit = req_i.bit_op && (req_i.addr[7:3] == xint_pkg::CTRL_ADDR[7:3]);
  wire port_bit = req_i.bit_op && (req_i.addr[7:3] == xint_pkg::PORT_ADDR[7:3]);
  wire [7:0] bit_mask = 8'h01 << req_i.addr[2:0];
  wire [7:0] bit_val = {8{req_i.wdata[0]}};

  wire ack2 = ack_i && (ack_source_i == 3'(xint_pkg::SRC_IRQ2));
  wire ack3 = ack_i && (ack_source_i == 3'(xint_pkg::SRC_IRQ3));
  wire ctrl_wr = req_i.wr && (ctrl_byte || ctrl_bit);
  wire [3:0] cfg_bits = {ctrl_r[xint_pkg::PRIO3_BIT], ctrl_r[xint_pkg::TRIG3_BIT], ctrl_r[xint_pkg::PRIO2_BIT], ctrl_r[xint_pkg::TRIG2_BIT]};

  // Software write first, then hardware: a detected edge wins over a clear.
  logic [7:0] ctrl_sw;
  assign ctrl_sw = (req_i.wr && ctrl_byte) ? req_i.wdata :
                   (req_i.wr && ctrl_bit) ? ((ctrl_r & ~bit_mask) | (bit_val & bit_mask)) : ctrl_r;
  wire trig2 = ctrl_r[xint_pkg::TRIG2_BIT];
  wire trig3 = ctrl_r[xint_pkg::TRIG3_BIT];
  wire pend2_nxt = trig2 ? ((ctrl_sw[xint_pkg::PEND2_BIT] & ~ack2) | fall2) : 1'b0;
  wire pend3_nxt = trig3 ? ((ctrl_sw[xint_pkg::PEND3_BIT] & ~ack3) | fall3) : 1'b0;
  always_comb
  begin
    ctrl_nxt = ctrl_sw;
    ctrl_nxt[xint_pkg::PEND2_BIT] = pend2_nxt;
    ctrl_nxt[xint_pkg::PEND3_BIT] = pend3_nxt;
  end

  // Only the low nibble reaches pins; upper latch bits are kept but drive nothing.
  assign port_nxt = (req_i.wr && port_byte) ? req_i.wdata :
                    (req_i.wr && port_bit) ? ((port_r & ~bit_mask) | (bit_val & bit_mask)) : port_r;

  // Level mode follows the pin directly, edge mode uses the pending flag.
  wire req2 = trig2 ? ctrl_r[xint_pkg::PEND2_BIT] : ~irq2_lvl;
  wire req3 = trig3 ? ctrl_r[xint_pkg::PEND3_BIT] : ~irq3_lvl;

  wire [7:0] req_all = {req3 & ctrl_r[xint_pkg::EN3_BIT], req2 & ctrl_r[xint_pkg::EN2_BIT], core_req_i};
  wire [7:0] prio_all = {ctrl_r[xint_pkg::PRIO3_BIT], ctrl_r[xint_pkg::PRIO2_BIT], core_prio_i};
  wire [7:0] hi_req = req_all & prio_all;
  wire [7:0] lo_req = req_all & ~prio_all;
  wire use_hi = |hi_req;
  wire [7:0] sel_req = use_hi ? hi_req : lo_req;

  logic [2:0] win;
  always_comb
  begin
    win = 3'h0;
    for (int i = xint_pkg::SOURCES - 1; i >= 0; i--)
      if (sel_req[i])
        win = 3'(i);
  end

  always_comb
  begin
    grant_nxt.valid = |req_all;
    grant_nxt.high = use_hi;
    grant_nxt.source = win;
    grant_nxt.vector = (|req_all) ? (xint_pkg::VEC_BASE + 8'({win, 3'h0})) : 8'h00;
  end

  // Port byte reads see the pins; the upper nibble reads back from the latch.
  assign rdata_nxt = ctrl_byte ? ctrl_r :
                     port_byte ? {port_r[7:4], pin_r} : 8'h00;

  always_ff @(posedge clk_i)
  begin
    if (!reset_n_i)
      ctrl_r <= xint_pkg::CTRL_RESET;
    else
      ctrl_r <= ctrl_nxt;
  end

  always_ff @(posedge clk_i)
  begin
    if (!reset_n_i)
      port_r <= xint_pkg::PORT_RESET;
    else
      port_r <= port_nxt;
  end

  // Synchronisers reset to the pull-up level so that release of reset shows no false edge.
  always_ff @(posedge clk_i)
  begin
    if (!reset_n_i)
    begin
      s1_r <= '1;
      s2_r <= '1;
      s3_r <= '1;
      pin_r <= '1;
    end
    else
    begin
      s1_r <= pin_i;
      s2_r <= s1_r;
      s3_r <= s2_r;
      pin_r <= pin_nxt;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (!reset_n_i)
      prev_r <= '1;
    else
      prev_r <= {irq3_lvl, irq2_lvl};
  end

  always_ff @(posedge clk_i)
  begin
    if (!reset_n_i)
    begin
      rdata_r <= '0;
      grant_r <= '0;
    end
    else
    begin
      rdata_r <= rdata_nxt;
      grant_r <= grant_nxt;
    end
  end

  // A latch one leaves the pin to the pull-up so the outside can pull it low.
  assign pin_o = 4'h0;
  assign pin_oe_n_o = port_r[3:0];
  assign rdata_o = rdata_r;
  assign grant_o = grant_r;

  edge_pend_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (trig2 && fall2 && $past(trig2)) |=> ctrl_r[xint_pkg::PEND2_BIT])
    else $error("edge did not set pending two");
  ack_clear_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (ack3 && !fall3 && !(req_i.wr && (ctrl_byte || ctrl_bit))) |=> !ctrl_r[xint_pkg::PEND3_BIT])
    else $error("acknowledge did not clear pending three");
  mask_req_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (!ctrl_r[xint_pkg::EN2_BIT] && !ctrl_r[xint_pkg::EN3_BIT] && core_req_i == 6'h00) |=> !grant_o.valid)
    else $error("masked request granted");
  level_follow_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (!trig2 && irq2_lvl) |-> !req2)
    else $error("level request latched");
  vector_map_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    grant_o.valid |-> grant_o.vector == 8'h03 + 8'({grant_o.source, 3'h0}))
    else $error("vector mismatch");
  poll_order_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (core_req_i[0] && !core_prio_i[0] && !use_hi) |=> grant_o.source == 3'h0)
    else $error("polling order broken");
  prio_high_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (req_all[7] && prio_all[7]) |=> grant_o.high)
    else $error("high priority lost");
  port_drive_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (req_i.wr && port_byte) |=> pin_oe_n_o == $past(req_i.wdata[3:0]))
    else $error("port write not driven");
  ctrl_bit_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (req_i.wr && ctrl_bit && req_i.addr == 8'hC2) |=> ctrl_r[xint_pkg::EN2_BIT] == $past(req_i.wdata[0]))
    else $error("bit write to enable two failed");

  ctrl_en_wr_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (req_i.wr && ctrl_byte)
    |=> ctrl_r[xint_pkg::EN2_BIT] == $past(req_i.wdata[xint_pkg::EN2_BIT]) && ctrl_r[xint_pkg::EN3_BIT] == $past(req_i.wdata[xint_pkg::EN3_BIT]))
    else $error("enable write lost");
  ctrl_prio_wr_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (req_i.wr && ctrl_byte)
    |=> ctrl_r[xint_pkg::PRIO2_BIT] == $past(req_i.wdata[xint_pkg::PRIO2_BIT]) && ctrl_r[xint_pkg::PRIO3_BIT] == $past(req_i.wdata[xint_pkg::PRIO3_BIT]))
    else $error("priority write lost");
  ctrl_trig_wr_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (req_i.wr && ctrl_byte)
    |=> ctrl_r[xint_pkg::TRIG2_BIT] == $past(req_i.wdata[xint_pkg::TRIG2_BIT]) && ctrl_r[xint_pkg::TRIG3_BIT] == $past(req_i.wdata[xint_pkg::TRIG3_BIT]))
    else $error("trigger write lost");
  en_hold_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    !ctrl_wr
    |=> ctrl_r[xint_pkg::EN2_BIT] == $past(ctrl_r[xint_pkg::EN2_BIT]) && ctrl_r[xint_pkg::EN3_BIT] == $past(ctrl_r[xint_pkg::EN3_BIT]))
    else $error("enable changed without write");
  cfg_hold_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    !ctrl_wr
    |=> cfg_bits == $past(cfg_bits))
    else $error("configuration changed without write");
  pend2_level_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    !trig2
    |=> !ctrl_r[xint_pkg::PEND2_BIT])
    else $error("pending two set in level mode");
  pend3_level_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    !trig3
    |=> !ctrl_r[xint_pkg::PEND3_BIT])
    else $error("pending three set in level mode");
  ack_clear2_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (ack2 && !fall2 && !ctrl_wr)
    |=> !ctrl_r[xint_pkg::PEND2_BIT])
    else $error("acknowledge did not clear pending two");
  edge_pend3_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (trig3 && fall3)
    |=> ctrl_r[xint_pkg::PEND3_BIT])
    else $error("edge did not set pending three");
  pend_hold2_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (trig2 && !fall2 && !ack2 && !ctrl_wr)
    |=> ctrl_r[xint_pkg::PEND2_BIT] == $past(ctrl_r[xint_pkg::PEND2_BIT]))
    else $error("pending two changed on its own");
  edge_quiet2_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (trig2 && !fall2 && !ctrl_r[xint_pkg::PEND2_BIT] && !ctrl_wr)
    |=> !ctrl_r[xint_pkg::PEND2_BIT])
    else $error("pending two set without falling edge");
  level_req2_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (!trig2 && !irq2_lvl && ctrl_r[xint_pkg::EN2_BIT])
    |=> grant_o.valid)
    else $error("low level two not requested");
  level_req3_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (!trig3 && !irq3_lvl && ctrl_r[xint_pkg::EN3_BIT])
    |=> grant_o.valid)
    else $error("low level three not requested");
  edge_grant2_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (trig2 && ctrl_r[xint_pkg::PEND2_BIT] && ctrl_r[xint_pkg::EN2_BIT])
    |=> grant_o.valid)
    else $error("pending two not requested");
  mask_src2_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    !ctrl_r[xint_pkg::EN2_BIT]
    |=> !(grant_o.valid && grant_o.source == 3'(xint_pkg::SRC_IRQ2)))
    else $error("masked source two granted");
  mask_src3_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    !ctrl_r[xint_pkg::EN3_BIT]
    |=> !(grant_o.valid && grant_o.source == 3'(xint_pkg::SRC_IRQ3)))
    else $error("masked source three granted");
  lo_only_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    ((|req_all) && !(|hi_req))
    |=> grant_o.valid && !grant_o.high)
    else $error("low request granted high");
  hi_wins_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (|hi_req)
    |=> grant_o.valid && grant_o.high)
    else $error("high request not preferred");
  grant_idle_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    !(|req_all)
    |=> grant_o == '0)
    else $error("grant without request");
  poll_first_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    hi_req[0]
    |=> grant_o.source == 3'h0)
    else $error("source zero not polled first");
  two_before3_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (sel_req[xint_pkg::SRC_IRQ2] && sel_req[xint_pkg::SRC_IRQ3] && sel_req[xint_pkg::SRC_IRQ2-1:0] == '0)
    |=> grant_o.source == 3'(xint_pkg::SRC_IRQ2))
    else $error("source three polled before two");
  port_bit_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (req_i.wr && port_bit)
    |=> port_r[$past(req_i.addr[2:0])] == $past(req_i.wdata[0]))
    else $error("port bit write lost");
  port_bit_only_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (req_i.wr && port_bit)
    |=> (port_r & ~$past(bit_mask)) == ($past(port_r) & ~$past(bit_mask)))
    else $error("port bit write touched other bits");
  port_hold_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    !(req_i.wr && (port_byte || port_bit))
    |=> $stable(port_r))
    else $error("port latch changed without write");
  port_latch_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (req_i.wr && port_byte)
    |=> port_r == $past(req_i.wdata))
    else $error("port byte write lost");
  rd_ctrl_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    ctrl_byte
    |=> rdata_o == $past(ctrl_r))
    else $error("control read wrong");
  rd_port_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    port_byte
    |=> rdata_o == {$past(port_r[7:4]), $past(pin_r)})
    else $error("port read wrong");
  rd_other_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    !(ctrl_byte || port_byte)
    |=> rdata_o == 8'h00)
    else $error("unmapped read not zero");
  sync_take_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (s2_r == s3_r)
    |=> pin_r == $past(s3_r))
    else $error("agreed pin level not taken");
endmodule

/* File: tb/ext_src.sv */
// External interrupt sources that pull the extra port pins.
// Assumes the pins carry pull-ups and the design only ever drives them low.
`timescale 1ns/1ps
module ext_src
(
  // Design side
  input wire logic [3:0] pin_oe_n_i,
  // Bench command, a zero pulls that pin low
  input wire logic [3:0] drive_i,
  output logic [3:0] pin_o
);
  // Open drain: either party pulling low wins, else the pull-up holds the pin high.
  assign pin_o = pin_oe_n_i & drive_i;
endmodule

/* File: tb/extra_ext_interrupts_port_tb.sv */
// Self-checking bench for the extra interrupt and extra port block.
// Assumes the external sources model in ext_src and a 200 MHz clock.
`timescale 1ns/1ps
module extra_ext_interrupts_port_tb;
  logic clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  xint_pkg::sfr_req_t req_i = '0;
  logic [5:0] core_req_i = 6'h00;
  logic [5:0] core_prio_i = 6'h00;
  logic ack_i = 1'b0;
  logic [2:0] ack_source_i = 3'h0;
  logic [3:0] drive = 4'hF;
  logic [3:0] pin_i;
  logic [7:0] rdata_o;
  logic [3:0] pin_oe_n_o;
  logic [3:0] pin_o;
  logic ok;
  xint_pkg::grant_t grant_o;
  logic [31:0] seed = 32'h7F361947;
  logic [7:0] ctrl;
  int num_errors = 0;
  int total_checks = 0;
  always #2.5 clk_i = ~clk_i;
  xint_port xint_port_i (.clk_i(clk_i), .reset_n_i(reset_n_i), .req_i(req_i), .rdata_o(rdata_o),
    .core_req_i(core_req_i), .core_prio_i(core_prio_i), .ack_i(ack_i), .ack_source_i(ack_source_i),
    .grant_o(grant_o), .pin_i(pin_i), .pin_o(pin_o), .pin_oe_n_o(pin_oe_n_o));
  ext_src ext_src_i (.pin_oe_n_i(pin_oe_n_o), .drive_i(drive), .pin_o(pin_i));
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // Low level first, then high, scanning downwards so the lowest index at the top level wins.
  function automatic xint_pkg::grant_t model(logic [7:0] rq, logic [7:0] hi);
    xint_pkg::grant_t g;
    g = '0;
    for (int k = 15; k >= 0; k--)
      if (rq[k % 8] && hi[k % 8] == (k < 8))
        g = '{1'b1, hi[k % 8], 3'(k % 8), 8'(3 + 8 * (k % 8))};
    return g;
  endfunction
  task automatic step(int n = 1);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  task automatic chk(logic [7:0] got, logic [7:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic chkg(xint_pkg::grant_t exp);
    total_checks++;
    if (grant_o !== exp)
    begin
      num_errors++;
      $display("BAD %0t grant %h want %h", $time, grant_o, exp);
    end
  endtask
  task automatic wr(logic [7:0] a, logic [7:0] d, logic b);
    req_i = '{1'b1, 1'b0, b, a, d};
    step();
    req_i.wr = 1'b0;
  endtask
  task automatic rd(logic [7:0] a, logic [7:0] exp);
    req_i = '{1'b0, 1'b1, 1'b0, a, 8'h00};
    step();
    chk(rdata_o, exp);
  endtask
  // Bounded wait for a grant; a timeout is reported here and counted as an error by the caller.
  task automatic wait_grant(output logic got);
    got = (grant_o.valid === 1'b1);
    for (int i = 0; i < 20 && !got; i++)
    begin
      step();
      got = (grant_o.valid === 1'b1);
    end
    if (!got)
      $display("BAD %0t grant timeout", $time);
  endtask
  task automatic conclude();
    $display("Checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial
  begin
    begin : body
      step(5);
      reset_n_i = 1'b1;
      rd(8'hC0, 8'h00);
      rd(8'hD8, 8'hFF);
      chk({4'h0, pin_oe_n_o}, 8'h0F);
      chk({4'h0, pin_o}, 8'h00);
      wr(8'hC2, 8'h01, 1'b1);
      rd(8'hC0, 8'h04);
      wr(8'hC0, 8'h00, 1'b0);
      wr(8'hD8, 8'h0A, 1'b0);
      step(5);
      rd(8'hD8, 8'h0A);
      chk({4'h0, pin_oe_n_o}, 8'h0A);
      wr(8'hD8, 8'hFF, 1'b0);
      wr(8'hD9, 8'h00, 1'b1);
      drive = 4'hE;
      step(5);
      rd(8'hD8, 8'hFC);
      rd(8'h80, 8'h00);
      wr(8'hD8, 8'hFF, 1'b0);
      drive = 4'hF;
      wr(8'hC0, 8'h05, 1'b0);
      step(3);
      drive = 4'hB;
      wait_grant(ok);
      if (!ok)
      begin
        num_errors++;
        disable body;
      end
      chkg('{1'b1, 1'b0, 3'h6, 8'h33});
      drive = 4'hF;
      step(5);
      rd(8'hC0, 8'h07);
      ack_i = 1'b1;
      ack_source_i = 3'h6;
      step();
      ack_i = 1'b0;
      rd(8'hC0, 8'h05);
      step();
      chkg('0);
      // Source three in edge mode at the high level, then serviced by its own acknowledge.
      wr(8'hC0, 8'hD0, 1'b0);
      step(3);
      drive = 4'h7;
      wait_grant(ok);
      if (!ok)
      begin
        num_errors++;
        disable body;
      end
      chkg('{1'b1, 1'b1, 3'h7, 8'h3B});
      drive = 4'hF;
      step(5);
      rd(8'hC0, 8'hF0);
      ack_i = 1'b1;
      ack_source_i = 3'h7;
      step();
      ack_i = 1'b0;
      rd(8'hC0, 8'hD0);
      step();
      chkg('0);
      // Level mode only: pending stays clear, so the request follows the pins directly.
      for (int r = 0; r < 40; r++)
      begin
        ctrl = 8'(rnd()) & 8'hCC;
        drive = 4'(rnd());
        wr(8'hC0, ctrl, 1'b0);
        step(6);
        for (int c = 0; c < 8; c++)
        begin
          core_req_i = 6'(rnd());
          core_prio_i = 6'(rnd());
          step();
          chkg(model({ctrl[6] & ~drive[3], ctrl[2] & ~drive[2], core_req_i}, {ctrl[7], ctrl[3], core_prio_i}));
        end
      end
    end
    conclude();
  end
endmodule
